// ### core/irq_params.svh
// Purpose: constants of the converter interrupt logic
// Assumes: register index times four is the APB byte address
// Notes: definitions only
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH

// register indices
`define IDX_CFG        8'h32
`define IDX_MASK       8'h33
`define IDX_FLAG       8'h36
`define IDX_IRQ_STAT   8'h40
`define IDX_IRQ_MASK   8'h41

// alert configuration fields
`define CFG_POL_BIT    7
`define CFG_MODE_HI    6
`define CFG_MODE_LO    5
`define CFG_FILT_BIT   2
`define CFG_WMASK      8'he4
`define CFG_RST        8'h00

// alert modes
`define MODE_LEVEL     2'h0
`define MODE_RSVD      2'h1
`define MODE_REPEAT    2'h2
`define MODE_ONESHOT   2'h3

// event bits
`define EV_ASP_BIT     7
`define EV_PLL_BIT     6
`define FLAG_VALID     8'hc0
`define FLAG_RST       8'h00
`define MASK_RST       8'hff

// interrupt status and mask (bit0 port clock error, bit1 lock)
`define IRQ_W          2
`define IRQ_STAT_RST   2'h0
`define IRQ_MASK_RST   2'h0

// timing
`define CLK_KHZ        250000
`define ALERT_ON_MS    2
`define ALERT_PERIOD_MS 4
`define TICK_W         20
`define MS_CNT_W       3

`endif

// ### core/irq_pkg.sv
// Purpose: types of the converter interrupt logic
// Assumes: irq_params.svh supplies the numbers
// Notes: apb request travels as one struct
package irq_pkg;

  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

  typedef enum logic [1:0] {
    ALERT_IDLE,
    ALERT_ON,
    ALERT_OFF
  } alert_state_t;

  // word index of a byte address, all ones when misaligned
  function automatic logic [7:0] reg_index(input logic [11:0] addr);
    reg_index = (addr[1:0] == 2'h0) ? addr[9:2] : 8'hff;
  endfunction

endpackage

// ### core/ms_tick.sv
// Purpose: one-cycle enable every millisecond
// Assumes: restart realigns the count to zero
// Notes: period is a parameter so simulation can shorten it
`timescale 1ns/10ps
`default_nettype none
`include "irq_params.svh"

module ms_tick #(
  parameter logic [`TICK_W-1:0] TICK_CYCLES = `TICK_W'(`CLK_KHZ)
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // control
  input  wire logic restart,
  output logic      tick
);

  logic [`TICK_W-1:0] cnt_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (restart) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (cnt_r == TICK_CYCLES - `TICK_W'(1)) begin
      cnt_r <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + `TICK_W'(1);
      tick  <= 1'b0;
    end
  end

endmodule // ms_tick
`default_nettype wire

// ### core/apb_port.sv
// Purpose: apb slave front end, zero wait states
// Assumes: read data and hit are valid in the setup cycle
// Notes: strobes fire at the completing access edge
`timescale 1ns/10ps
`default_nettype none

module apb_port
  import irq_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // bus side
  input  wire apb_req_t    req,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // register side
  input  wire logic [31:0] rdata,
  input  wire logic        hit,
  output logic             wr_stb,
  output logic             rd_stb
);

  logic done;

  assign done   = req.sel & req.enable & pready;
  assign wr_stb = done & req.write & ~pslverr;
  assign rd_stb = done & ~req.write & ~pslverr;

  // read data captured at setup so clear-on-read clears exactly what was shown
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (req.sel & ~req.enable) begin
      pready  <= 1'b1;
      prdata  <= (hit & ~req.write) ? rdata : 32'h0000_0000;
      pslverr <= ~hit;
    end else if (done) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // apb_port
`default_nettype wire

// ### core/audio_adc_irq_logic.sv
// Purpose: event latches, masks and alert pin of the converter
// Assumes: event inputs are asynchronous levels, a rise is one event
// Notes: apb registers plus a sticky interrupt status with w1c
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "irq_params.svh"

// Functional notes
// [RL1] mode 0: alert held while unmasked flag set
// [RL2] mode 2: 2 ms on per 4 ms while pending
// [RL3] mode 3: one 2 ms pulse per unmasked event
// [RL4] filter 0: flag read shows all events
// [RL5] filter 1: flag read hides masked events
// [RL6] mask bit 7 gates port clock error
// [RL7] mask bit 6 gates lock event
// [RL8] mask resets to all ones, all writable
// [RL9] flag bit 7 latches port clock error
// [RL10] flag bit 6 latches lock; reset zero
// [RL11] config bit 7 selects alert polarity
// [RL12] flag read clears; simultaneous event survives
// [RL13] events latch regardless of mask
module audio_adc_irq_logic
  import irq_pkg::*;
#(
  parameter logic [`TICK_W-1:0] TICK_CYCLES = `TICK_W'(`CLK_KHZ)
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // event sources
  input  wire logic        asp_clk_err_in,
  input  wire logic        pll_lock_in,
  // outputs
  output logic             alert_out,
  output logic             irq_out
);

  apb_req_t           req;
  logic [7:0]         idx;
  logic [31:0]        rdata;
  logic               hit;
  logic               wr_stb;
  logic               rd_stb;
  logic [7:0]         cfg_r;
  logic [7:0]         mask_r;
  logic [7:0]         flag_r;
  logic [7:0]         flag_nxt;
  logic [7:0]         ev_set;
  logic [`IRQ_W-1:0]  istat_r;
  logic [`IRQ_W-1:0]  imask_r;
  logic [1:0]         ev_in;
  logic [1:0]         filt_r;
  logic [1:0]         prev_r;
  logic [1:0]         mode;
  logic               pending;
  logic               new_ev;
  logic               tick;
  logic               restart;
  logic               act_nxt;
  logic               act_r;
  alert_state_t       st_r;
  logic [`MS_CNT_W-1:0] ms_r;

  assign req   = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
  assign idx   = reg_index(paddr);
  assign mode  = cfg_r[`CFG_MODE_HI:`CFG_MODE_LO];
  assign ev_in = {asp_clk_err_in, pll_lock_in};

  // three-stage synchronisers; a level counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      logic [2:0] s_r;
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          s_r       <= 3'h0;
          filt_r[g] <= 1'b0;
          prev_r[g] <= 1'b0;
        end else begin
          s_r       <= {s_r[1:0], ev_in[g]};
          prev_r[g] <= filt_r[g];
          if (s_r[1] == s_r[2])
            filt_r[g] <= s_r[2];
        end
      end
    end
  endgenerate

  always_comb begin
    ev_set              = 8'h00;
    ev_set[`EV_ASP_BIT] = filt_r[1] & ~prev_r[1];
    ev_set[`EV_PLL_BIT] = filt_r[0] & ~prev_r[0];
  end

  assign pending = |(flag_r & ~mask_r & `FLAG_VALID); // see [RL6] see [RL7]
  assign new_ev  = |(ev_set & ~mask_r);

  // register read mux and decode
  always_comb begin
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    case (idx)
      `IDX_CFG:      rdata[7:0] = cfg_r;
      `IDX_MASK:     rdata[7:0] = mask_r;
      `IDX_FLAG: begin
        if (cfg_r[`CFG_FILT_BIT])
          rdata[7:0] = flag_r & ~mask_r; // see [RL5]
        else
          rdata[7:0] = flag_r; // see [RL4]
      end
      `IDX_IRQ_STAT: rdata[`IRQ_W-1:0] = istat_r;
      `IDX_IRQ_MASK: rdata[`IRQ_W-1:0] = imask_r;
      default:       hit = 1'b0;
    endcase
  end

  apb_port u_apb (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .req     (req),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr),
    .rdata   (rdata),
    .hit     (hit),
    .wr_stb  (wr_stb),
    .rd_stb  (rd_stb)
  );

  // configuration; reserved bits stay zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      cfg_r <= `CFG_RST;
    else if (wr_stb && idx == `IDX_CFG)
      cfg_r <= pwdata[7:0] & `CFG_WMASK;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      mask_r <= `MASK_RST; // see [RL8]
    else if (wr_stb && idx == `IDX_MASK)
      mask_r <= pwdata[7:0]; // see [RL8]
  end

  // clear only what the read returned; a new event in that cycle wins
  always_comb begin
    flag_nxt = flag_r;
    if (rd_stb && idx == `IDX_FLAG)
      flag_nxt = flag_nxt & ~prdata[7:0]; // see [RL12]
    flag_nxt = flag_nxt | ev_set; // see [RL9] see [RL10] see [RL13]
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      flag_r <= `FLAG_RST; // see [RL10]
    else
      flag_r <= flag_nxt;
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_r <= `IRQ_STAT_RST;
      imask_r <= `IRQ_MASK_RST;
    end else begin
      if (wr_stb && idx == `IDX_IRQ_MASK)
        imask_r <= pwdata[`IRQ_W-1:0];
      istat_r <= (istat_r & ~((wr_stb && idx == `IDX_IRQ_STAT) ?
                 pwdata[`IRQ_W-1:0] : `IRQ_W'(0)))
                 | {ev_set[`EV_PLL_BIT], ev_set[`EV_ASP_BIT]};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      irq_out <= 1'b0;
    else
      irq_out <= |(istat_r & imask_r);
  end

  // pulse timing: millisecond enable, restarted when a pulse starts from idle or a one-shot pulse retriggers
  assign restart = (st_r == ALERT_IDLE) ? ((mode == `MODE_REPEAT) & pending) |
                   ((mode == `MODE_ONESHOT) & new_ev) :
                   ((st_r == ALERT_ON) & (mode == `MODE_ONESHOT) & new_ev);

  ms_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .restart (restart),
    .tick    (tick)
  );

  // pulse sequencer; a retrigger during a one-shot pulse restarts it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ALERT_IDLE;
      ms_r <= '0;
    end else begin
      case (st_r)
        ALERT_IDLE: begin
          ms_r <= '0;
          if (restart)
            st_r <= ALERT_ON; // see [RL2] see [RL3]
        end
        ALERT_ON: begin
          if (restart)
            ms_r <= '0;
          else if (mode == `MODE_REPEAT && !pending) begin
            st_r <= ALERT_IDLE;
            ms_r <= '0;
          end else if (tick && ms_r == `MS_CNT_W'(`ALERT_ON_MS - 1)) begin
            ms_r <= '0;
            st_r <= (mode == `MODE_REPEAT) ? ALERT_OFF : ALERT_IDLE; // see [RL3]
          end else if (tick)
            ms_r <= ms_r + `MS_CNT_W'(1);
        end
        ALERT_OFF: begin
          if (mode != `MODE_REPEAT || !pending) begin
            st_r <= ALERT_IDLE;
            ms_r <= '0;
          end else if (tick &&
                       ms_r == `MS_CNT_W'(`ALERT_PERIOD_MS - `ALERT_ON_MS - 1)) begin
            ms_r <= '0;
            st_r <= ALERT_ON; // see [RL2]
          end else if (tick)
            ms_r <= ms_r + `MS_CNT_W'(1);
        end
        default: begin
          st_r <= ALERT_IDLE;
          ms_r <= '0;
        end
      endcase
    end
  end

  // reserved mode never asserts
  always_comb begin
    case (mode)
      `MODE_LEVEL:   act_nxt = pending; // see [RL1]
      `MODE_REPEAT:  act_nxt = (st_r == ALERT_ON) & pending;
      `MODE_ONESHOT: act_nxt = (st_r == ALERT_ON);
      default:       act_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_r     <= 1'b0;
      alert_out <= 1'b1;
    end else begin
      act_r     <= act_nxt;
      alert_out <= cfg_r[`CFG_POL_BIT] ? act_nxt : ~act_nxt; // see [RL11]
    end
  end

  // checks
  property p_level_mode;
    @(posedge sys_clk) disable iff (!rst_n)
      (mode == `MODE_LEVEL && pending) |=> act_r;
  endproperty
  a_level_mode: assert property (p_level_mode) // see [RL1]
    else $error("level mode alert not asserted");

  property p_polarity;
    @(posedge sys_clk) disable iff (!rst_n)
      ##1 (alert_out == ($past(cfg_r[`CFG_POL_BIT]) ? act_r : ~act_r));
  endproperty
  a_polarity: assert property (p_polarity) // see [RL11]
    else $error("alert pin polarity wrong");

  property p_repeat_stops;
    @(posedge sys_clk) disable iff (!rst_n)
      (mode == `MODE_REPEAT && !pending) |=> !act_r;
  endproperty
  a_repeat_stops: assert property (p_repeat_stops) // see [RL2]
    else $error("repeat alert active without pending event");

  property p_oneshot_start;
    @(posedge sys_clk) disable iff (!rst_n)
      (mode == `MODE_ONESHOT && new_ev && $stable(cfg_r)) |=> ##1 act_r;
  endproperty
  a_oneshot_start: assert property (p_oneshot_start) // see [RL3]
    else $error("one-shot pulse missing");

  property p_masked_quiet;
    @(posedge sys_clk) disable iff (!rst_n)
      (mode == `MODE_LEVEL && (flag_r & ~mask_r & `FLAG_VALID) == 8'h00) |=> !act_r;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) // see [RL6]
    else $error("masked event drove the alert");

  property p_latch;
    @(posedge sys_clk) disable iff (!rst_n)
      (ev_set[`EV_ASP_BIT]) |=> flag_r[`EV_ASP_BIT];
  endproperty
  a_latch: assert property (p_latch) // see [RL9]
    else $error("port clock error not latched");

  property p_read_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      (rd_stb && idx == `IDX_FLAG && ev_set == 8'h00)
        |=> (flag_r & $past(prdata[7:0])) == 8'h00;
  endproperty
  a_read_clear: assert property (p_read_clear) // see [RL12]
    else $error("flag read did not clear shown bits");

  property p_filter;
    @(posedge sys_clk) disable iff (!rst_n)
      (psel && !penable && !pwrite && idx == `IDX_FLAG && cfg_r[`CFG_FILT_BIT])
        |=> (prdata[7:0] & $past(mask_r)) == 8'h00;
  endproperty
  a_filter: assert property (p_filter) // see [RL5]
    else $error("masked flag visible in filtered read");

  property p_irq;
    @(posedge sys_clk) disable iff (!rst_n)
      (|(istat_r & imask_r)) |=> irq_out;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output not raised");

  c_repeat: cover property (@(posedge sys_clk) disable iff (!rst_n)
    st_r == ALERT_OFF ##1 st_r == ALERT_ON);
  c_oneshot: cover property (@(posedge sys_clk) disable iff (!rst_n)
    mode == `MODE_ONESHOT && act_r);
  c_clear: cover property (@(posedge sys_clk) disable iff (!rst_n)
    rd_stb && idx == `IDX_FLAG && prdata[7:0] != 8'h00);
  c_irq: cover property (@(posedge sys_clk) disable iff (!rst_n) irq_out);

endmodule // audio_adc_irq_logic
`default_nettype wire

// ### verif/host_monitor.sv
// Purpose: host side model watching the alert pin
// Assumes: active level of the pin given by the bench
// Notes: counts pulses and active cycles since the last clear
`timescale 1ns/10ps
`default_nettype none

module host_monitor (
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  // alert pin and control
  input  wire logic   alert_out,
  input  wire logic   active_high,
  input  wire logic   clear,
  // counts
  output logic [7:0]  pulses,
  output logic [15:0] on_cycles
);
  logic act;
  logic act_r;

  // level compare, so either polarity is seen the same way
  assign act = (alert_out == active_high);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_r     <= 1'b0;
      pulses    <= 8'h00;
      on_cycles <= 16'h0000;
    end else if (clear) begin
      act_r     <= act;
      pulses    <= 8'h00;
      on_cycles <= 16'h0000;
    end else begin
      act_r     <= act;
      pulses    <= pulses + 8'((act && !act_r) ? 1 : 0);
      on_cycles <= on_cycles + 16'(act ? 1 : 0);
    end
  end
endmodule // host_monitor

`default_nettype wire

// ### verif/test_audio_adc_irq_logic.sv
// Purpose: self-checking bench of the converter interrupt logic
// Assumes: tick shortened to 10 cycles per ms
// Notes: apb tasks, event pulses, host model counts alert pulses
`timescale 1ns/10ps
`default_nettype none
`include "irq_params.svh"

module test_audio_adc_irq_logic;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        asp_clk_err_in = 1'b0;
  logic        pll_lock_in = 1'b0;
  logic        alert_out;
  logic        irq_out;
  logic        pol = 1'b0;
  logic        mon_clr = 1'b0;
  logic [7:0]  pulses;
  logic [15:0] on_cycles;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch = 0;
  int          n_checks = 0;

  audio_adc_irq_logic #(.TICK_CYCLES(`TICK_W'(10))) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .asp_clk_err_in(asp_clk_err_in),
    .pll_lock_in(pll_lock_in), .alert_out(alert_out), .irq_out(irq_out));

  host_monitor host (
    .sys_clk(sys_clk), .rst_n(rst_n), .alert_out(alert_out),
    .active_high(pol), .clear(mon_clr), .pulses(pulses), .on_cycles(on_cycles));

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // idle cycle after release so a following call never re-drives in one step
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no cycle limit here: only the watchdog ends a wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  // one rise, then low long enough for the flag to settle
  task automatic ev(input logic asp);
    if (asp) asp_clk_err_in <= 1'b1;
    else pll_lock_in <= 1'b1;
    repeat (3) @(posedge sys_clk);
    asp_clk_err_in <= 1'b0;
    pll_lock_in    <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic clr();
    mon_clr <= 1'b1;
    @(posedge sys_clk);
    mon_clr <= 1'b0;
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdc(`IDX_MASK, 32'hff);
    rdc(`IDX_FLAG, 32'h00);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, `IDX_MASK, 32'h15);
    rdc(`IDX_MASK, 32'h15);
    // masked event still latches, pin stays quiet
    apb(1'b1, `IDX_MASK, 32'hff);
    ev(1'b1);
    chk(32'(alert_out), 32'h1);
    rdc(`IDX_FLAG, 32'h80);
    rdc(`IDX_FLAG, 32'h00);
    // readback filter
    apb(1'b1, `IDX_MASK, 32'h7f);
    apb(1'b1, `IDX_CFG, 32'h04);
    ev(1'b1);
    ev(1'b0);
    rdc(`IDX_FLAG, 32'h80);
    apb(1'b1, `IDX_CFG, 32'h00);
    rdc(`IDX_FLAG, 32'h40);
    // level mode, reserved mode, both polarities
    apb(1'b1, `IDX_MASK, 32'hbf);
    ev(1'b0);
    chk(32'(alert_out), 32'h0);
    // pin follows a config write one edge after the write edge
    apb(1'b1, `IDX_CFG, 32'h20);
    @(posedge sys_clk);
    chk(32'(alert_out), 32'h1);
    apb(1'b1, `IDX_CFG, 32'h80);
    @(posedge sys_clk);
    chk(32'(alert_out), 32'h1);
    rdc(`IDX_FLAG, 32'h40);
    repeat (3) @(posedge sys_clk);
    chk(32'(alert_out), 32'h0);
    // repeating pulse while pending
    pol <= 1'b1;
    apb(1'b1, `IDX_CFG, 32'hc0);
    clr();
    ev(1'b0);
    repeat (60) @(posedge sys_clk);
    chk(32'(pulses), 32'h2);
    rdc(`IDX_FLAG, 32'h40);
    repeat (45) @(posedge sys_clk);
    chk(32'(alert_out), 32'h0);
    // one-shot pulse, never repeated although flag stays set
    apb(1'b1, `IDX_MASK, 32'h7f);
    apb(1'b1, `IDX_CFG, 32'he0);
    clr();
    ev(1'b1);
    repeat (100) @(posedge sys_clk);
    chk(32'(pulses), 32'h1);
    chk(32'(on_cycles >= 16'd20 && on_cycles <= 16'd21), 32'h1);
    rdc(`IDX_FLAG, 32'h80);
    // interrupt status, mask and write-one-to-clear
    apb(1'b1, `IDX_IRQ_STAT, 32'h3);
    rdc(`IDX_IRQ_STAT, 32'h0);
    apb(1'b1, `IDX_IRQ_MASK, 32'h1);
    ev(1'b0);
    chk(32'(irq_out), 32'h0);
    ev(1'b1);
    chk(32'(irq_out), 32'h1);
    rdc(`IDX_IRQ_STAT, 32'h3);
    apb(1'b1, `IDX_IRQ_STAT, 32'h1);
    @(posedge sys_clk);
    chk(32'(irq_out), 32'h0);
    rdc(`IDX_IRQ_STAT, 32'h2);
    conclude();
  end
endmodule // test_audio_adc_irq_logic

`default_nettype wire
